/* logic/ttr_consts.svh */
// constants for the touch threshold and recalibration control block
// Behaviour
// - broadcast bit: input one write loads all
// - broadcast clear: each threshold written individually
// - input two, three writes always individual
// - noise clears intermediate accumulation unless kept
// - noise clears negative counter unless kept
// - negative count trigger 8/16/32 or disabled
// - recal samples 16..256, codes 5-7 256
// - update period 16..256,1024,2048,4096 poll ticks
// - average samples before base update, separate period
// - recal settings shared, per-input enable separate
// - touch when delta exceeds threshold, reset 40h
// - noise spike excluded from recalibration
// - noise disable bit turns off spike exclusion
// - noise threshold 25/37.5/50/62.5 percent
// - standby samples only enabled inputs
// - standby inputs use standby threshold
// - standby threshold register resets to 40h
`ifndef TTR_CONSTS_SVH
`define TTR_CONSTS_SVH
`define TTR_ADDR_RECAL      8'h2f
`define TTR_ADDR_TH1        8'h30
`define TTR_ADDR_TH2        8'h31
`define TTR_ADDR_TH3        8'h32
`define TTR_ADDR_NOISE      8'h38
`define TTR_ADDR_STBY_SEL   8'h40
`define TTR_ADDR_STBY_TH    8'h43
`define TTR_RST_RECAL       8'h8a
`define TTR_RST_TH          8'h40
`define TTR_RST_NOISE       8'h01
`define TTR_RST_STBY_SEL    8'h00
`define TTR_BIT_BCAST       7
`define TTR_BIT_KEEP_INTD   6
`define TTR_BIT_KEEP_NEG    5
`define TTR_NEG_HI          4
`define TTR_NEG_LO          3
`define TTR_CAL_HI          2
`define TTR_NOISE_HI        1
`define TTR_STBY_HI         2
`define TTR_TH_MASK         8'h7f
`endif

/* logic/ttr_pkg.sv */
// types for the touch threshold and recalibration control block
package ttr_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ttr_reg_req_s;
    typedef struct packed {
        logic       valid;
        logic [1:0] input_idx;
        logic       negative;
        logic [7:0] delta;
        logic [15:0] raw;
    } ttr_sample_s;
    typedef enum logic [2:0] {
        TTR_ACCUM = 3'b001,
        TTR_WAIT  = 3'b010,
        TTR_LOAD  = 3'b100
    } ttr_recal_e;
endpackage

/* logic/ttr_noise_class.sv */
// classifies one sample as touch, noise spike or quiet
`timescale 1ns/100ps
`include "ttr_consts.svh"
module ttr_noise_class (
    input  wire logic [7:0] delta,
    input  wire logic [7:0] threshold,
    input  wire logic [1:0] noise_threshold_sel,
    input  wire logic       digital_noise_disable,
    output logic            touch,
    output logic            noise_spike
);
    import ttr_pkg::*;
    logic [10:0] noise_lvl;
    logic [10:0] th8;
    // noise level in eighths of the touch threshold: 2,3,4,5 eighths
    always_comb begin
        th8       = {3'h0, threshold};
        noise_lvl = 11'((th8 * (11'h2 + {9'h0, noise_threshold_sel})) >> 3);
        touch     = delta > threshold;
        noise_spike = !digital_noise_disable && !touch &&
                      ({3'h0, delta} > noise_lvl);
    end
endmodule

/* logic/ttr_recal_chan.sv */
// per-input recalibration: negative counter, sample averaging, base update
`timescale 1ns/100ps
`include "ttr_consts.svh"
module ttr_recal_chan (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        sample_valid,
    input  wire logic        sample_negative,
    input  wire logic [15:0] sample_raw,
    input  wire logic        noise,
    input  wire logic        recal_en,
    input  wire logic        keep_intermediate_on_noise,
    input  wire logic        keep_negative_counter_on_noise,
    input  wire logic [5:0]  neg_limit,
    input  wire logic [8:0]  sample_target,
    input  wire logic [12:0] period_target,
    input  wire logic        poll_tick,
    output logic             neg_recal,
    output logic [15:0]      base
);
    import ttr_pkg::*;
    logic [5:0]  neg_cnt, next_neg_cnt;
    logic [8:0]  samp_cnt, next_samp_cnt;
    logic [24:0] acc, next_acc;
    logic [12:0] per_cnt, next_per_cnt;
    logic [15:0] next_base;
    logic        next_neg_recal;
    ttr_recal_e  state, next_state;
    // next-state for counters, accumulator and base count
    always_comb begin
        next_neg_cnt   = neg_cnt;
        next_samp_cnt  = samp_cnt;
        next_acc       = acc;
        next_per_cnt   = per_cnt;
        next_base      = base;
        next_neg_recal = 1'b0;
        next_state     = state;
        if (poll_tick && per_cnt < period_target)
            next_per_cnt = per_cnt + 13'h1;
        if (sample_valid && noise) begin
            if (!keep_negative_counter_on_noise) next_neg_cnt = 6'h0;
            if (!keep_intermediate_on_noise) begin
                next_acc      = 25'h0;
                next_samp_cnt = 9'h0;
            end
        end else if (sample_valid) begin
            if (sample_negative && neg_limit != 6'h0) begin
                if (neg_cnt + 6'h1 >= neg_limit) begin
                    next_neg_recal = 1'b1;
                    next_neg_cnt   = 6'h0;
                    next_base      = sample_raw;
                end else
                    next_neg_cnt = neg_cnt + 6'h1;
            end else if (!sample_negative)
                next_neg_cnt = 6'h0;
            if (recal_en && state == TTR_ACCUM) begin
                next_acc      = acc + {9'h0, sample_raw};
                next_samp_cnt = samp_cnt + 9'h1;
                if (samp_cnt + 9'h1 >= sample_target) next_state = TTR_WAIT;
            end
        end
        case (state)
            TTR_ACCUM: ;
            TTR_WAIT: if (per_cnt >= period_target) next_state = TTR_LOAD;
            TTR_LOAD: begin
                next_base     = 16'(acc / {16'h0, sample_target});
                next_acc      = 25'h0;
                next_samp_cnt = 9'h0;
                next_per_cnt  = 13'h0;
                next_state    = TTR_ACCUM;
            end
            default: next_state = TTR_ACCUM;
        endcase
    end
    // register stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            neg_cnt <= 6'h0; samp_cnt <= 9'h0; acc <= 25'h0; per_cnt <= 13'h0;
            base <= 16'h0; neg_recal <= 1'b0; state <= TTR_ACCUM;
        end else begin
            neg_cnt <= next_neg_cnt; samp_cnt <= next_samp_cnt; acc <= next_acc;
            per_cnt <= next_per_cnt; base <= next_base; neg_recal <= next_neg_recal;
            state <= next_state;
        end
    end
endmodule

/* logic/ttr_top.sv */
// register file and touch decision for three sensor inputs
`timescale 1ns/100ps
`include "ttr_consts.svh"
module ttr_top (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire ttr_pkg::ttr_reg_req_s reg_req,
    output logic [7:0]                rd_data,
    input  wire ttr_pkg::ttr_sample_s sample,
    input  wire logic                 poll_tick,
    input  wire logic                 standby,
    input  wire logic                 digital_noise_disable,
    input  wire logic [2:0]           recal_input_en,
    output logic [2:0]                touch_status,
    output logic [2:0]                noise_status,
    output logic [2:0]                recal_event,
    output logic [2:0]                sample_enable,
    output logic [47:0]               base_counts
);
    import ttr_pkg::*;
    logic [1:0] rst_sync;
    logic       rst_n_int;
    logic [7:0] recal_config, next_recal_config;
    logic [7:0] th [3], next_th [3];
    logic [7:0] noise_threshold_config, next_noise_threshold_config;
    logic [7:0] standby_input_select, next_standby_input_select;
    logic [7:0] standby_threshold, next_standby_threshold;
    logic [7:0] next_rd_data;
    logic [2:0] next_touch, next_noise, next_sample_enable;
    logic [2:0] cls_touch, cls_noise, neg_recal;
    logic [15:0] base_w [3];
    logic [5:0]  neg_limit;
    logic [8:0]  sample_target;
    logic [12:0] period_target;

    function automatic logic wr_hit(input ttr_reg_req_s r, input logic [7:0] a);
        wr_hit = r.wr && r.addr == a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) rst_sync <= 2'b00;
        else        rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n_int = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_comb begin
        next_recal_config           = recal_config;
        next_noise_threshold_config = noise_threshold_config;
        next_standby_input_select   = standby_input_select;
        next_standby_threshold      = standby_threshold;
        for (int i = 0; i < 3; i++) next_th[i] = th[i];
        if (wr_hit(reg_req, `TTR_ADDR_RECAL)) next_recal_config = reg_req.wdata;
        if (wr_hit(reg_req, `TTR_ADDR_TH1)) begin
            next_th[0] = reg_req.wdata;
            if (recal_config[`TTR_BIT_BCAST]) begin
                next_th[1] = reg_req.wdata;
                next_th[2] = reg_req.wdata;
            end // otherwise only input one changes
        end
        if (wr_hit(reg_req, `TTR_ADDR_TH2)) next_th[1] = reg_req.wdata;
        if (wr_hit(reg_req, `TTR_ADDR_TH3)) next_th[2] = reg_req.wdata;
        if (wr_hit(reg_req, `TTR_ADDR_NOISE))
            next_noise_threshold_config = {6'h0, reg_req.wdata[`TTR_NOISE_HI:0]};
        if (wr_hit(reg_req, `TTR_ADDR_STBY_SEL))
            next_standby_input_select = {5'h0, reg_req.wdata[`TTR_STBY_HI:0]};
        if (wr_hit(reg_req, `TTR_ADDR_STBY_TH))
            next_standby_threshold = reg_req.wdata & `TTR_TH_MASK;
    end
    // register storage, defaults from reset
    always_ff @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            recal_config           <= `TTR_RST_RECAL;
            for (int i = 0; i < 3; i++) th[i] <= `TTR_RST_TH;
            noise_threshold_config <= `TTR_RST_NOISE;
            standby_input_select   <= `TTR_RST_STBY_SEL;
            standby_threshold      <= `TTR_RST_TH;
        end else begin
            recal_config           <= next_recal_config;
            for (int i = 0; i < 3; i++) th[i] <= next_th[i];
            noise_threshold_config <= next_noise_threshold_config;
            standby_input_select   <= next_standby_input_select;
            standby_threshold      <= next_standby_threshold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared recalibration settings decode
    always_comb begin
        case (recal_config[`TTR_NEG_HI:`TTR_NEG_LO])
            2'b00:   neg_limit = 6'd8;
            2'b01:   neg_limit = 6'd16;
            2'b10:   neg_limit = 6'd32;
            default: neg_limit = 6'd0;
        endcase
        case (recal_config[`TTR_CAL_HI:0])
            3'd0:    begin sample_target = 9'd16;  period_target = 13'd16;   end
            3'd1:    begin sample_target = 9'd32;  period_target = 13'd32;   end
            3'd2:    begin sample_target = 9'd64;  period_target = 13'd64;   end
            3'd3:    begin sample_target = 9'd128; period_target = 13'd128;  end
            3'd4:    begin sample_target = 9'd256; period_target = 13'd256;  end
            3'd5:    begin sample_target = 9'd256; period_target = 13'd1024; end
            3'd6:    begin sample_target = 9'd256; period_target = 13'd2048; end
            default: begin sample_target = 9'd256; period_target = 13'd4096; end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // per-input classification and recalibration
    for (genvar g = 0; g < 3; g++) begin : g_in
        logic hit;
        logic [7:0] eff_th;
        assign eff_th = standby ? standby_threshold : th[g];
        assign hit = sample.valid && sample.input_idx == 2'(g) &&
                     (!standby || standby_input_select[g]);
        ttr_noise_class u_cls (
            .delta                 (sample.delta),
            .threshold             (eff_th),
            .noise_threshold_sel   (noise_threshold_config[`TTR_NOISE_HI:0]),
            .digital_noise_disable (digital_noise_disable),
            .touch                 (cls_touch[g]),
            .noise_spike           (cls_noise[g])
        );
        ttr_recal_chan u_rc (
            .sys_clk                        (sys_clk),
            .rst_n                          (rst_n_int),
            .sample_valid                   (hit && !cls_touch[g]),
            .sample_negative                (sample.negative),
            .sample_raw                     (sample.raw),
            .noise                          (cls_noise[g]),
            .recal_en                       (recal_input_en[g]),
            .keep_intermediate_on_noise     (recal_config[`TTR_BIT_KEEP_INTD]),
            .keep_negative_counter_on_noise (recal_config[`TTR_BIT_KEEP_NEG]),
            .neg_limit                      (neg_limit),
            .sample_target                  (sample_target),
            .period_target                  (period_target),
            .poll_tick                      (poll_tick),
            .neg_recal                      (neg_recal[g]),
            .base                           (base_w[g])
        );
        assign base_counts[g*16 +: 16] = base_w[g];
        always_comb begin
            next_touch[g]         = hit ? cls_touch[g] : touch_status[g];
            next_noise[g]         = hit ? cls_noise[g] : noise_status[g];
            next_sample_enable[g] = !standby || standby_input_select[g];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data and status registers
    always_comb begin
        case (reg_req.addr)
            `TTR_ADDR_RECAL:    next_rd_data = recal_config;
            `TTR_ADDR_TH1:      next_rd_data = th[0];
            `TTR_ADDR_TH2:      next_rd_data = th[1];
            `TTR_ADDR_TH3:      next_rd_data = th[2];
            `TTR_ADDR_NOISE:    next_rd_data = noise_threshold_config;
            `TTR_ADDR_STBY_SEL: next_rd_data = standby_input_select;
            `TTR_ADDR_STBY_TH:  next_rd_data = standby_threshold;
            default:            next_rd_data = 8'h00;
        endcase
        if (!reg_req.rd) next_rd_data = rd_data;
    end
    always_ff @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            rd_data <= 8'h00; touch_status <= 3'h0; noise_status <= 3'h0;
            recal_event <= 3'h0; sample_enable <= 3'h0;
        end else begin
            rd_data <= next_rd_data; touch_status <= next_touch; noise_status <= next_noise;
            recal_event <= neg_recal; sample_enable <= next_sample_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    bcast_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        wr_hit(reg_req, `TTR_ADDR_TH1) && recal_config[`TTR_BIT_BCAST] |=>
        th[1] == $past(reg_req.wdata) && th[2] == $past(reg_req.wdata))
        else $error("broadcast write missed");
    bcast_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        wr_hit(reg_req, `TTR_ADDR_TH1) && !recal_config[`TTR_BIT_BCAST] |=> $stable(th[1]))
        else $error("input two changed without broadcast");
    th_two_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        wr_hit(reg_req, `TTR_ADDR_TH2) |=> th[1] == $past(reg_req.wdata))
        else $error("input two write lost");
    neg_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        recal_config[`TTR_NEG_HI:`TTR_NEG_LO] == 2'b11 |-> neg_limit == 6'd0)
        else $error("disabled trigger has limit");
    period_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        recal_config[`TTR_CAL_HI:0] == 3'd5 |-> period_target == 13'd1024 && sample_target == 9'd256)
        else $error("code five decode wrong");
    touch_cls_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        sample.valid && sample.input_idx == 2'd0 && !standby && sample.delta > th[0]
        |=> touch_status[0])
        else $error("touch missed");
    stby_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        standby && !standby_input_select[0] |=> !sample_enable[0])
        else $error("standby input sampled");
    noise_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        digital_noise_disable |-> cls_noise == 3'h0)
        else $error("noise flagged while disabled");
endmodule

/* tb/ttr_front_model.sv */
// sensing front end model: turns bench requests into one-cycle sample pulses
`timescale 1ns/100ps
module ttr_front_model (
    input  wire logic            sys_clk,
    input  wire logic            go,
    input  wire logic [1:0]      idx,
    input  wire logic            neg,
    input  wire logic [7:0]      dlt,
    output ttr_pkg::ttr_sample_s sample
);
    import ttr_pkg::*;
    logic       take;
    logic       take_neg;
    logic [1:0] take_idx;
    logic [7:0] take_dlt;
    logic [7:0] last;
    initial begin
        sample = '0;
        last   = 8'h00;
    end
    // request sampled on the edge, pulse driven just after it
    always @(posedge sys_clk) begin
        take     = go;
        take_idx = idx;
        take_neg = neg;
        take_dlt = dlt;
        #1;
        if (take) begin
            sample = '{valid: 1'b1, input_idx: take_idx, negative: take_neg, delta: take_dlt, raw: {8'h10, take_dlt}};
            last   = take_dlt;
        end else begin
            // idle lines never repeat the last delta
            sample = '{valid: 1'b0, input_idx: ~take_idx, negative: ~take_neg, delta: ~last, raw: 16'h0000};
            last   = ~last;
        end
    end
endmodule

/* tb/tb.sv */
// self-checking bench for the touch threshold and recalibration block
`timescale 1ns/100ps
`include "ttr_consts.svh"
module tb;
    import ttr_pkg::*;
    typedef struct {logic [1:0] sel; logic dis; logic [7:0] dlt; logic tch; logic nse;} ttr_row_s;
    logic         sys_clk, rst_n, poll_tick, standby, digital_noise_disable, go, neg;
    logic [1:0]   idx;
    logic [7:0]   dlt, rd_data;
    logic [2:0]   touch_status, noise_status, recal_event, sample_enable, recal_en;
    logic [47:0]  base_counts;
    ttr_reg_req_s reg_req;
    ttr_sample_s  sample;
    int           bad_count, compares, cycles, ev_cnt, base_ev;
    ttr_row_s     rows [10];
    logic [7:0]   dflt_addr [8] = '{8'h2f, 8'h30, 8'h31, 8'h32, 8'h38, 8'h40, 8'h43, 8'h50};
    logic [7:0]   dflt_val  [8] = '{8'h8a, 8'h40, 8'h40, 8'h40, 8'h01, 8'h00, 8'h40, 8'h00};

    ttr_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .rd_data(rd_data), .sample(sample),
        .poll_tick(poll_tick), .standby(standby), .digital_noise_disable(digital_noise_disable),
        .recal_input_en(recal_en), .touch_status(touch_status), .noise_status(noise_status),
        .recal_event(recal_event), .sample_enable(sample_enable), .base_counts(base_counts));
    ttr_front_model fe (.sys_clk(sys_clk), .go(go), .idx(idx), .neg(neg), .dlt(dlt), .sample(sample));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, poll pulses, event counting and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (recal_event[0] === 1'b1) ev_cnt++;
        #1;
        poll_tick = (cycles % 8 == 0);
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        #1;
        reg_req = '0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        #1;
        reg_req = '0;
        @(posedge sys_clk);
        #1;
        check(rd_data, exp);
    endtask
    task automatic send(input logic [1:0] i, input logic n, input logic [7:0] d);
        go  = 1'b1;
        idx = i;
        neg = n;
        dlt = d;
        @(posedge sys_clk);
        #1;
        go = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic end_sim();
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_n = 1'b0;
        poll_tick = 1'b0;
        standby = 1'b0;
        digital_noise_disable = 1'b0;
        go = 1'b0;
        neg = 1'b0;
        idx = 2'd0;
        dlt = 8'h00;
        reg_req = '0;
        recal_en = 3'b111;
        // noise level is threshold 40h times (2+sel)/8
        rows = '{'{0, 0, 8'h11, 0, 1}, '{0, 0, 8'h10, 0, 0}, '{1, 0, 8'h19, 0, 1}, '{1, 0, 8'h18, 0, 0},
                 '{2, 0, 8'h21, 0, 1}, '{3, 0, 8'h29, 0, 1}, '{3, 0, 8'h28, 0, 0}, '{1, 0, 8'h41, 1, 0},
                 '{1, 0, 8'h40, 0, 1}, '{1, 1, 8'h19, 0, 0}};
        repeat (4) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        // touch and noise classification table
        foreach (rows[r]) begin
            digital_noise_disable = rows[r].dis;
            reg_wr(8'h38, {6'h00, rows[r].sel});
            send(2'd0, 1'b0, rows[r].dlt);
            check({7'h00, touch_status[0]}, {7'h00, rows[r].tch});
            check({7'h00, noise_status[0]}, {7'h00, rows[r].nse});
        end
        digital_noise_disable = 1'b0;
        // negative delta trigger at 8, 16, 32, then disabled; keep bits equal
        for (int c = 0; c < 4; c++) begin
            reg_wr(8'h2f, {3'b100, c[1:0], 3'b101});
            send(2'd0, 1'b0, 8'h00);
            base_ev = ev_cnt;
            repeat ((c == 3) ? 40 : (8 << c) - 1) send(2'd0, 1'b1, 8'h00);
            check(8'(ev_cnt - base_ev), 8'h00);
            if (c < 3) begin
                send(2'd0, 1'b1, 8'h00);
                repeat (2) @(posedge sys_clk);
                #1;
                check(8'(ev_cnt - base_ev), 8'h01);
            end
        end
        // noise sample clears or keeps the negative counter
        for (int k = 0; k < 2; k++) begin
            reg_wr(8'h2f, {1'b1, k[0], k[0], 5'b00010});
            send(2'd0, 1'b0, 8'h00);
            base_ev = ev_cnt;
            repeat (4) send(2'd0, 1'b1, 8'h00);
            send(2'd0, 1'b1, 8'h20);
            repeat (4) send(2'd0, 1'b1, 8'h00);
            repeat (2) @(posedge sys_clk);
            #1;
            check(8'(ev_cnt - base_ev), {7'h00, k[0]});
        end
        // standby: selected inputs only, standby threshold
        reg_wr(8'h40, 8'h05);
        reg_wr(8'h43, 8'h10);
        send(2'd1, 1'b0, 8'h00);
        standby = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check({5'h00, sample_enable}, 8'h05);
        send(2'd0, 1'b0, 8'h11);
        check({7'h00, touch_status[0]}, 8'h01);
        send(2'd1, 1'b0, 8'h7f);
        check({7'h00, touch_status[1]}, 8'h00);
        send(2'd2, 1'b0, 8'h11);
        check({7'h00, touch_status[2]}, 8'h01);
        standby = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check({5'h00, sample_enable}, 8'h07);
        send(2'd0, 1'b0, 8'h11);
        check({7'h00, touch_status[0]}, 8'h00);
        // threshold broadcast set, then clear
        reg_wr(8'h2f, 8'h8a);
        reg_wr(8'h30, 8'h55);
        reg_rd(8'h31, 8'h55);
        reg_rd(8'h32, 8'h55);
        reg_wr(8'h31, 8'h22);
        reg_rd(8'h31, 8'h22);
        reg_rd(8'h30, 8'h55);
        reg_wr(8'h2f, 8'h0a);
        reg_wr(8'h30, 8'h11);
        reg_wr(8'h32, 8'h33);
        reg_rd(8'h30, 8'h11);
        reg_rd(8'h31, 8'h22);
        reg_rd(8'h32, 8'h33);
        // second reset mid-run, defaults and an unmapped address
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check({5'h00, touch_status}, 8'h00);
        rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        foreach (dflt_addr[k]) reg_rd(dflt_addr[k], dflt_val[k]);
        // averaged base update after the full sample count, per-input enable
        recal_en = 3'b101;
        reg_wr(8'h2f, 8'h80);
        repeat (15) begin
            send(2'd0, 1'b0, 8'h00);
            send(2'd1, 1'b0, 8'h00);
        end
        repeat (200) @(posedge sys_clk);
        #1;
        check(base_counts[15:8], 8'h00);
        send(2'd0, 1'b0, 8'h00);
        send(2'd1, 1'b0, 8'h00);
        repeat (200) @(posedge sys_clk);
        #1;
        check(base_counts[15:8], 8'h10);
        check(base_counts[7:0], 8'h00);
        check(base_counts[31:24], 8'h00);
        end_sim();
    end
endmodule
